// File: ees_pkg.sv
// Shared constants and types for the two-wire memory slave engine.
// Assumes a single 100 MHz system clock that samples both bus lines.
//
// Overview of operation
// - Data moves only while serial clock low.
// - Data falling, clock high: start, begin frame.
// - Data rising, clock high: stop, standby.
// - Eight-bit words, device acknowledges on ninth clock.
// - Standby at power-up and after finished stop.
// - Start/nine clocks/start/stop recovers the device.
// - First word is address; type pattern must match.
// - Address bits three to one: upper word address.
// - Address bit zero high reads, low writes.
// - Match acknowledges; mismatch returns to standby.
// - Byte write: address, word address, data, stop.
// - Programming after write stop ignores the bus.
// - Programming time runs from the stop onward.
// - Page writes up to sixteen bytes, all acknowledged.
// - Writes increment low four bits, wrapping in page.
// - Extra page bytes wrap and overwrite earlier ones.
// - Address polls acknowledged only after programming ends.
// - Address counter holds last address plus one.
// - Reads wrap from array end to start.
// - Current read returns byte at counter address.
// - Random read: dummy write, repeated start, read.
// - Acknowledged read bytes advance; nack plus stop ends.
// - Sample on clock rise, change after fall.
// - Array holds 128 pages of sixteen bytes.
package ees_pkg;

   localparam int ADDR_W = 11;
   localparam int PAGE_OFS_W = 4;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_COUNT = 128;
   localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;

   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] BIT_CNT_ONE = 4'h1;
   localparam logic [3:0] PAGE_OFS_ONE = 4'h1;
   localparam logic [10:0] ADDR_ONE = 11'h001;
   localparam logic [10:0] ADDR_RESET = 11'h000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] MASK_ZERO = 16'h0000;

   // Programming time in microseconds and the derived clock count.
   localparam int CLK_MHZ = 100;
   localparam int T_PROG_US = 5000;
   localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEV_ADDR,
      ST_DEV_ACK,
      ST_WORD_ADDR,
      ST_WORD_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK
   } ees_state_t;

endpackage

// File: ees_prog_if.sv
`timescale 1ns/1ps
// Handshake between the protocol engine and the programming timer.
// Assumes both ends run on the same system clock.
interface ees_prog_if;
   logic start;
   logic busy;
   logic done;
   modport ctl (output start, input busy, input done);
   modport tmr (input start, output busy, output done);
endinterface

// File: ees_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with edge detection for one bus line.
// Assumes the input is asynchronous to the system clock.
module ees_sync #(
   parameter logic IDLE_LEVEL = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } ees_sync_st_t;

   ees_sync_st_t r, nxt;

   // The edge detector compares the second and third stages only.
   always_comb begin
      nxt = r;
      nxt.meta = i_pin;
      nxt.sync = r.meta;
      nxt.prev = r.sync;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '{meta: IDLE_LEVEL, sync: IDLE_LEVEL, prev: IDLE_LEVEL};
      end else begin
         r <= nxt;
      end
   end

   assign o_level = r.sync;
   assign o_rise = r.sync & ~r.prev;
   assign o_fall = ~r.sync & r.prev;

endmodule

// File: ees_prog_timer.sv
`timescale 1ns/1ps
// Self-timed programming cycle counter.
// Assumes start is a one-cycle pulse that is only given while idle.
module ees_prog_timer #(
   parameter int CYCLES = ees_pkg::PROG_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   ees_prog_if.tmr prog
);

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic busy;
      logic done;
   } ees_tmr_st_t;

   ees_tmr_st_t r, nxt;

   always_comb begin
      nxt = r;
      nxt.done = 1'b0;
      if (r.busy) begin
         if (r.cnt == CNT_ZERO) begin
            nxt.busy = 1'b0;
            nxt.done = 1'b1;
         end else begin
            nxt.cnt = r.cnt - CNT_ONE;
         end
      end else if (prog.start) begin
         nxt.busy = 1'b1;
         nxt.cnt = CNT_LOAD;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '{cnt: CNT_ZERO, busy: 1'b0, done: 1'b0};
      end else begin
         r <= nxt;
      end
   end

   assign prog.busy = r.busy;
   assign prog.done = r.done;

endmodule

// File: ees_slave.sv
`timescale 1ns/1ps
// Two-wire serial memory slave: protocol engine, page buffer and array.
// Assumes an external pull-up resolves the data line from O_SDA_OE.
// Assumes both bus lines arrive unsynchronised from the board.
module ees_slave #(
   parameter int PROG_CYCLES = ees_pkg::PROG_CYCLES
) (
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   output logic O_SDA,
   output logic O_SDA_OE,
   output logic O_STANDBY,
   output logic O_PROG_BUSY
);

   // ------------------------------------------------------------------
   // Line synchronisers and bus conditions
   // ------------------------------------------------------------------
   logic scl_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic sda_rise;
   logic sda_fall;

   ees_sync #(.IDLE_LEVEL(1'b1)) u_scl_sync (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_pin(I_SCL),
      .o_level(scl_lvl),
      .o_rise(scl_rise),
      .o_fall(scl_fall)
   );

   ees_sync #(.IDLE_LEVEL(1'b1)) u_sda_sync (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_pin(I_SDA),
      .o_level(sda_lvl),
      .o_rise(sda_rise),
      .o_fall(sda_fall)
   );

   logic start_cond;
   logic stop_cond;

   // A data edge with the clock high is never data, only a condition.
   assign start_cond = sda_fall & scl_lvl;
   assign stop_cond = sda_rise & scl_lvl;

   // ------------------------------------------------------------------
   // Programming timer
   // ------------------------------------------------------------------
   // The timer owns the busy level; the engine only sends it a pulse.
   ees_prog_if prog ();

   ees_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .prog(prog.tmr)
   );

   // ------------------------------------------------------------------
   // Array and engine state
   // ------------------------------------------------------------------
   logic [7:0] mem [ees_pkg::MEM_BYTES];
   logic [7:0] rd_byte;

   // The array stays outside this record; only engine state is here.
   typedef struct packed {
      ees_pkg::ees_state_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic [10:0] addr;
      logic rw;
      logic master_ack;
      logic data_seen;
      logic sda_oe;
      logic prog_start;
      logic standby;
      logic [15:0][7:0] page_buf;
      logic [15:0] page_mask;
   } ees_st_t;

   ees_st_t r, nxt;

   assign rd_byte = mem[r.addr];

   // ------------------------------------------------------------------
   // Word decode and counter arithmetic
   // ------------------------------------------------------------------
   // Page bits only matter for a write address; a read keeps the counter.
   logic [3:0] word_type;
   logic [2:0] word_page;
   logic word_dir;
   logic type_match;
   logic word_done;
   logic [3:0] bit_cnt_inc;
   logic [7:0] shreg_in;
   logic [7:0] shreg_out;
   logic [3:0] page_ofs;
   logic [3:0] page_ofs_inc;
   logic [10:0] addr_inc;

   assign word_type = r.shreg[7:4];
   assign word_page = r.shreg[3:1];
   assign word_dir = r.shreg[0];
   assign type_match = (word_type == ees_pkg::DEV_TYPE);
   assign word_done = (r.bit_cnt == ees_pkg::BITS_PER_WORD);
   assign bit_cnt_inc = r.bit_cnt + ees_pkg::BIT_CNT_ONE;
   assign shreg_in = {r.shreg[6:0], sda_lvl};
   assign shreg_out = {r.shreg[6:0], 1'b0};
   assign page_ofs = r.addr[3:0];
   // Only the low four bits count, so a long page write stays in its page.
   assign page_ofs_inc = page_ofs + ees_pkg::PAGE_OFS_ONE;
   // The eleven-bit sum wraps from the last byte of the array to zero.
   assign addr_inc = r.addr + ees_pkg::ADDR_ONE;

   // ------------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------------
   // Start and stop are tested ahead of the state case, so either one
   // restarts the engine from any state; bus recovery depends on that.
   always_comb begin
      nxt = r;
      nxt.prog_start = 1'b0;
      if (start_cond) begin
         // While programming, starts are ignored so polls see no ack.
         nxt.sda_oe = 1'b0;
         nxt.bit_cnt = ees_pkg::BIT_CNT_ZERO;
         if (prog.busy) begin
            nxt.st = ees_pkg::ST_IDLE;
         end else begin
            nxt.st = ees_pkg::ST_DEV_ADDR;
         end
      end else if (stop_cond) begin
         nxt.sda_oe = 1'b0;
         nxt.st = ees_pkg::ST_IDLE;
         if (r.data_seen && !prog.busy) begin
            nxt.prog_start = 1'b1;
         end
         nxt.data_seen = 1'b0;
      end else begin
         case (r.st)
            ees_pkg::ST_IDLE: begin
               nxt.sda_oe = 1'b0;
            end
            ees_pkg::ST_DEV_ADDR,
            ees_pkg::ST_WORD_ADDR,
            ees_pkg::ST_WR_DATA: begin
               if (scl_rise) begin
                  nxt.shreg = shreg_in;
                  nxt.bit_cnt = bit_cnt_inc;
               end else if (scl_fall && word_done) begin
                  nxt.sda_oe = 1'b1;
                  if (r.st == ees_pkg::ST_DEV_ADDR) begin
                     if (type_match) begin
                        nxt.st = ees_pkg::ST_DEV_ACK;
                        nxt.rw = word_dir;
                        if (!word_dir) begin
                           nxt.addr[10:8] = word_page;
                           nxt.page_mask = ees_pkg::MASK_ZERO;
                           nxt.data_seen = 1'b0;
                        end
                     end else begin
                        nxt.sda_oe = 1'b0;
                        nxt.st = ees_pkg::ST_IDLE;
                     end
                  end else if (r.st == ees_pkg::ST_WORD_ADDR) begin
                     nxt.addr[7:0] = r.shreg;
                     nxt.st = ees_pkg::ST_WORD_ACK;
                  end else begin
                     // Later bytes of an overlong page overwrite slots.
                     nxt.page_buf[page_ofs] = r.shreg;
                     nxt.page_mask[page_ofs] = 1'b1;
                     nxt.data_seen = 1'b1;
                     nxt.addr[3:0] = page_ofs_inc;
                     nxt.st = ees_pkg::ST_WR_ACK;
                  end
               end
            end
            ees_pkg::ST_DEV_ACK: begin
               if (scl_fall) begin
                  nxt.bit_cnt = ees_pkg::BIT_CNT_ZERO;
                  if (r.rw) begin
                     // Each loaded byte advances the counter past it.
                     nxt.shreg = rd_byte;
                     nxt.addr = addr_inc;
                     nxt.sda_oe = ~rd_byte[7];
                     nxt.st = ees_pkg::ST_RD_DATA;
                  end else begin
                     nxt.sda_oe = 1'b0;
                     nxt.st = ees_pkg::ST_WORD_ADDR;
                  end
               end
            end
            ees_pkg::ST_WORD_ACK,
            ees_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  nxt.sda_oe = 1'b0;
                  nxt.bit_cnt = ees_pkg::BIT_CNT_ZERO;
                  nxt.st = ees_pkg::ST_WR_DATA;
               end
            end
            ees_pkg::ST_RD_DATA: begin
               if (scl_rise) begin
                  nxt.bit_cnt = bit_cnt_inc;
               end else if (scl_fall) begin
                  if (word_done) begin
                     nxt.sda_oe = 1'b0;
                     nxt.st = ees_pkg::ST_RD_ACK;
                  end else begin
                     nxt.sda_oe = ~r.shreg[6];
                     nxt.shreg = shreg_out;
                  end
               end
            end
            ees_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  nxt.master_ack = ~sda_lvl;
               end else if (scl_fall) begin
                  nxt.bit_cnt = ees_pkg::BIT_CNT_ZERO;
                  if (r.master_ack) begin
                     // An acknowledged byte asks for the next one in order.
                     nxt.shreg = rd_byte;
                     nxt.addr = addr_inc;
                     nxt.sda_oe = ~rd_byte[7];
                     nxt.st = ees_pkg::ST_RD_DATA;
                  end else begin
                     nxt.sda_oe = 1'b0;
                     nxt.st = ees_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               nxt.sda_oe = 1'b0;
               nxt.st = ees_pkg::ST_IDLE;
            end
         endcase
      end
      // The start pulse is still in flight for one cycle before busy rises.
      nxt.standby = (nxt.st == ees_pkg::ST_IDLE) && !prog.busy &&
                    !r.prog_start && !nxt.prog_start;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // The page buffer is cleared too, so no stale byte can be committed.
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         r.st <= ees_pkg::ST_IDLE;
         r.bit_cnt <= ees_pkg::BIT_CNT_ZERO;
         r.shreg <= ees_pkg::BYTE_ZERO;
         r.addr <= ees_pkg::ADDR_RESET;
         r.rw <= 1'b0;
         r.master_ack <= 1'b0;
         r.data_seen <= 1'b0;
         r.sda_oe <= 1'b0;
         r.prog_start <= 1'b0;
         r.standby <= 1'b1;
         r.page_buf <= '0;
         r.page_mask <= ees_pkg::MASK_ZERO;
      end else begin
         r <= nxt;
      end
   end

   // ------------------------------------------------------------------
   // Array commit
   // ------------------------------------------------------------------
   // The page is committed when the timer expires, so a read can never
   // see a half-written page; the array itself has no reset.
   always_ff @(posedge I_CLOCK) begin
      if (prog.done) begin
         for (int i = 0; i < ees_pkg::PAGE_BYTES; i++) begin
            if (r.page_mask[i]) begin
               mem[{r.addr[10:4], 4'(i)}] <= r.page_buf[i];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Programming trigger
   // ------------------------------------------------------------------
   // A dummy write carries no data byte, so its stop programs nothing.
   assign prog.start = r.prog_start;

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Open drain: the pin only ever pulls low when enabled.
   assign O_SDA = 1'b0;
   assign O_SDA_OE = r.sda_oe;
   assign O_STANDBY = r.standby;
   assign O_PROG_BUSY = prog.busy;

endmodule

// File: ees_slave_checker.sv
`timescale 1ns/1ps
// Pin-level checks on the two-wire memory slave.
// Assumes it is bound into each slave and shares its clock and reset.
module ees_slave_checker #(
   parameter int PROG_CYCLES = ees_pkg::PROG_CYCLES
) (
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic O_SDA,
   input wire logic O_SDA_OE,
   input wire logic O_STANDBY,
   input wire logic O_PROG_BUSY
);
   int busy_cnt_r;

   // Counts busy cycles so the programming length is bounded to a window of three counts.
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= O_PROG_BUSY ? busy_cnt_r + 1 : 0;
      end
   end

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_ARST_N);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_drive_zero:
      assert property (O_SDA_OE |-> !O_SDA && !I_SDA)
      else $error("acknowledge drive does not pull the line low");
   chk_oe_low_clock:
      assert property ($changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2))
      else $error("data drive changed outside clock low time");
   chk_busy_min:
      assert property ($fell(O_PROG_BUSY) |->
         busy_cnt_r >= PROG_CYCLES && busy_cnt_r <= PROG_CYCLES + 2)
      else $error("programming cycle length is wrong");
   chk_busy_max:
      assert property (O_PROG_BUSY |-> busy_cnt_r <= PROG_CYCLES + 1)
      else $error("programming cycle runs too long");
   chk_busy_no_ack:
      assert property (O_PROG_BUSY |-> !O_SDA_OE)
      else $error("acknowledge given while programming");
   chk_busy_not_idle:
      assert property (O_PROG_BUSY |-> !O_STANDBY)
      else $error("standby shown while programming");
   chk_idle_after_prog:
      assert property ($fell(O_PROG_BUSY) |-> ##[0:1] O_STANDBY)
      else $error("no standby after programming ends");
   chk_prog_after_stop:
      assert property ($rose(O_PROG_BUSY) |->
         I_SCL && I_SDA && !$past(I_SDA, 8))
      else $error("programming began without a stop");
   chk_idle_quiet:
      assert property (O_STANDBY |-> !O_SDA_OE)
      else $error("data line pulled while in standby");
endmodule

bind ees_slave ees_slave_checker #(.PROG_CYCLES(PROG_CYCLES))
   ees_slave_checker_i (
   .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_SCL(I_SCL), .I_SDA(I_SDA),
   .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_STANDBY(O_STANDBY),
   .O_PROG_BUSY(O_PROG_BUSY));

// File: ees_bus_master.sv
`timescale 1ns/1ps
// Two-wire bus master model: 80 ns clock, open-drain data drive.
// Assumes the bench resolves the data line with a pull-up.
module ees_bus_master (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // The clock stands high between frames, as a real master leaves it.
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // Data moves two cycles into the low time; read at end of high.
   task automatic bit_c(input logic v, output logic r);
      tick(2);
      o_sda_low = ~v;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      r = i_sda;
      o_scl = 1'b0;
   endtask

   task automatic start_c();
      if (o_scl === 1'b0) begin
         tick(2);
         o_sda_low = 1'b0;
         tick(3);
         o_scl = 1'b1;
      end
      tick(4);
      o_sda_low = 1'b1;
      tick(4);
      o_scl = 1'b0;
   endtask

   task automatic stop_c();
      tick(2);
      o_sda_low = 1'b1;
      tick(3);
      o_scl = 1'b1;
      tick(4);
      o_sda_low = 1'b0;
      tick(8);
   endtask

   task automatic put_byte(input logic [7:0] b, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_c(b[i], r);
      bit_c(1'b1, nak);
   endtask

   task automatic get_byte(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, r);
         b[i] = r;
      end
      bit_c(~ack, r);
   endtask
endmodule

// File: ees_slave_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the two-wire memory slave.
// Assumes the master model drives the bus and the checker is bound in.
`define CHK(got, exp) check_val((got), (exp))
module ees_slave_tb_top;
   localparam int PROG = 400;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic scl, m_low, o_sda, o_oe, o_stby, o_busy, nak;
   wire logic sda_w;
   logic [7:0] rd;
   int error_cnt = 0;
   int compares = 0;

   always #5 clk = ~clk;
   // Pull-up: the line is low while either party pulls it.
   assign sda_w = ~(m_low | (o_oe & ~o_sda));

   ees_bus_master ees_bus_master_i (.i_clk(clk), .i_sda(sda_w),
      .o_scl(scl), .o_sda_low(m_low));
   ees_slave #(.PROG_CYCLES(PROG)) ees_slave_i (.I_CLOCK(clk),
      .I_ARST_N(arst_n), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(o_sda),
      .O_SDA_OE(o_oe), .O_STANDBY(o_stby), .O_PROG_BUSY(o_busy));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic send(input logic [7:0] b, input logic exp_nak);
      ees_bus_master_i.put_byte(b, nak);
      `CHK(nak, exp_nak);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (o_busy !== 1'b0 && n < 2 * PROG) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2 * PROG) begin
         error_cnt++;
         $display("timeout waiting for programming to end");
         test_done();
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      `CHK(o_oe, 1'b0);
      `CHK(o_stby, 1'b1);
      `CHK(o_busy, 1'b0);
      `CHK(o_sda, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_byte_write();
      ees_bus_master_i.start_c();
      send(8'hA0, 1'b0);
      send(8'h00, 1'b0);
      send(8'hC3, 1'b0);
      ees_bus_master_i.stop_c();
      `CHK(o_busy, 1'b1);
      `CHK(o_stby, 1'b0);
      ees_bus_master_i.start_c();
      send(8'hA0, 1'b1);
      ees_bus_master_i.stop_c();
      wait_idle();
      repeat (2) @(negedge clk);
      `CHK(o_stby, 1'b1);
      ees_bus_master_i.start_c();
      send(8'hA0, 1'b0);
      ees_bus_master_i.stop_c();
      `CHK(o_busy, 1'b0);
      $display("test byte write done");
   endtask

   task automatic t_page_write();
      ees_bus_master_i.start_c();
      send(8'hAE, 1'b0);
      send(8'hF8, 1'b0);
      for (int i = 0; i < 17; i++) begin
         send(8'h10 + i[7:0], 1'b0);
      end
      ees_bus_master_i.stop_c();
      wait_idle();
      $display("test page write done");
   endtask

   task automatic t_seq_read();
      logic [7:0] exp;
      ees_bus_master_i.start_c();
      send(8'hAE, 1'b0);
      send(8'hF1, 1'b0);
      ees_bus_master_i.start_c();
      send(8'hAF, 1'b0);
      // The seventeenth byte replaced the first one, at offset 8.
      for (int o = 1; o < 16; o++) begin
         exp = (o > 8) ? 8'h08 + o[7:0] : 8'h18 + o[7:0];
         if (o == 8) exp = 8'h20;
         ees_bus_master_i.get_byte(o < 15, rd);
         `CHK(rd, exp);
      end
      ees_bus_master_i.stop_c();
      `CHK(o_stby, 1'b1);
      ees_bus_master_i.start_c();
      send(8'hA1, 1'b0);
      ees_bus_master_i.get_byte(1'b0, rd);
      `CHK(rd, 8'hC3);
      ees_bus_master_i.stop_c();
      $display("test sequential read done");
   endtask

   task automatic t_recover();
      logic r;
      ees_bus_master_i.start_c();
      send(8'h52, 1'b1);
      `CHK(o_stby, 1'b1);
      ees_bus_master_i.start_c();
      send(8'hA0, 1'b0);
      for (int i = 0; i < 4; i++) ees_bus_master_i.bit_c(1'b1, r);
      ees_bus_master_i.start_c();
      for (int i = 0; i < 9; i++) ees_bus_master_i.bit_c(1'b1, r);
      ees_bus_master_i.start_c();
      ees_bus_master_i.stop_c();
      `CHK(o_busy, 1'b0);
      ees_bus_master_i.start_c();
      send(8'hA0, 1'b0);
      send(8'h00, 1'b0);
      ees_bus_master_i.start_c();
      send(8'hA1, 1'b0);
      ees_bus_master_i.get_byte(1'b0, rd);
      `CHK(rd, 8'hC3);
      ees_bus_master_i.stop_c();
      $display("test recovery done");
   endtask

   initial begin
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_byte_write();
      t_page_write();
      t_seq_read();
      t_recover();
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      test_done();
   end
endmodule
